//--- src/jid_pkg.sv
package jid_pkg;
	localparam int IR_W   = 10;
	localparam int UC_W   = 32;
	localparam int ID_W   = 32;
	localparam int BS_W   = 8;
	localparam int IOC_W  = 8;
	localparam logic [IR_W-1:0] IR_SAMPLE   = 10'h005;
	localparam logic [IR_W-1:0] IR_EXTEST   = 10'h00f;
	localparam logic [IR_W-1:0] IR_BYPASS   = 10'h3ff;
	localparam logic [IR_W-1:0] IR_USERCODE = 10'h007;
	localparam logic [IR_W-1:0] IR_IDENT    = 10'h006;
	localparam logic [IR_W-1:0] IR_HIGHZ    = 10'h00b;
	localparam logic [IR_W-1:0] IR_CLAMP    = 10'h00a;
	localparam logic [IR_W-1:0] IR_PULSE    = 10'h001;
	localparam logic [IR_W-1:0] IR_CFGIO    = 10'h00d;
	localparam logic [IR_W-1:0] IR_RESET    = 10'h006;
	localparam logic [1:0] IR_CAPTURE       = 2'h1;
	// arbitrary identity value
	localparam logic [ID_W-1:0] ID_VALUE    = 32'h0000_1001;
	typedef enum logic [3:0] {
		JID_RESET = 4'h0, JID_IDLE = 4'h1, JID_SEL_DR = 4'h3, JID_CAP_DR = 4'h2,
		JID_SH_DR = 4'h6, JID_EX1_DR = 4'h7, JID_PAU_DR = 4'h5, JID_EX2_DR = 4'h4,
		JID_UPD_DR = 4'hc, JID_SEL_IR = 4'hd, JID_CAP_IR = 4'hf, JID_SH_IR = 4'he,
		JID_EX1_IR = 4'ha, JID_PAU_IR = 4'hb, JID_EX2_IR = 4'h9, JID_UPD_IR = 4'h8
	} jid_tap_t;
endpackage

//--- src/jid_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface jid_sync_if;
	logic tog;
	logic busy;
	modport src (output tog, input busy);
	modport dst (input tog, output busy);
endinterface
`default_nettype wire

//--- src/jid_pulse_sync.sv
`timescale 1ns/1ps
`default_nettype none
// level crossing: one pulse out per rising request; a falling request is ignored
module jid_pulse_sync (
	// system side
	input  wire logic sys_clk,
	input  wire logic rst_n,
	jid_sync_if.dst   link,
	output logic      pulse
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} jid_ps_t;
	jid_ps_t r, next_r;
	always_comb begin
		next_r = r;
		next_r.s1 = link.tog;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			r <= '0;
		else
			r <= next_r;
	end
	assign pulse = r.s2 & ~r.s3;
	assign link.busy = r.s1 | r.s2 | r.s3;
endmodule
`default_nettype wire

//--- src/jid_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - sample/preload captures pins, preloads pattern
// - extest drives pattern, captures input pins
// - bypass puts one-bit register in path
// - usercode shifts 32-bit user code out
// - ident shifts identification value out
// - highz: bypass path, all pins floated
// - clamp: bypass path, pins hold scan data
// - pulse instruction requests reconfiguration internally
// - io config loads standards any time
// - io config aborts ongoing configuration
// - status held low until io update or tap reset
// - bus hold or pull-up beats float
module jid_decoder
	import jid_pkg::*;
(
	// test port, link clock domain
	input  wire logic              tck,
	input  wire logic              tms,
	input  wire logic              tdi,
	output logic                   tdo,
	output logic                   tdo_oe,
	// system clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// pins seen by the scan cells
	input  wire logic [jid_pkg::BS_W-1:0]  pin_in,
	input  wire logic [jid_pkg::BS_W-1:0]  core_out,
	input  wire logic [jid_pkg::BS_W-1:0]  core_oe,
	input  wire logic [jid_pkg::BS_W-1:0]  pin_keep,
	output logic [jid_pkg::BS_W-1:0]       pin_out,
	output logic [jid_pkg::BS_W-1:0]       pin_oe,
	output logic [jid_pkg::BS_W-1:0]       pin_keep_on,
	// configuration control
	input  wire logic [jid_pkg::UC_W-1:0]  user_code,
	input  wire logic              config_busy,
	output logic                   reconfig_pulse,
	output logic                   config_abort,
	output logic                   config_status_n,
	output logic [jid_pkg::IOC_W-1:0]      io_element_cfg
);
	import jid_pkg::*;

	typedef struct packed {
		jid_tap_t         st;
		logic [IR_W-1:0]  ir_sh;
		logic [IR_W-1:0]  ir;
		logic             byp;
		logic [UC_W-1:0]  dr32;
		logic [BS_W-1:0]  bs_sh;
		logic [BS_W-1:0]  bs_upd;
		logic [IOC_W-1:0] ioc_sh;
		logic [IOC_W-1:0] ioc;
		logic             hold_low;
		logic             tdo;
		logic             tdo_oe;
		logic             rc_req;
		logic             ab_req;
		logic             busy1;
		logic             busy2;
	} jid_link_t;

	jid_link_t t, next_t;

	// the link side has no reset pin: five tck cycles with tms high bring it to a known state
	// unknown codes fall through to the one-bit bypass path
	wire logic sel_byp = (t.ir == IR_BYPASS) || (t.ir == IR_HIGHZ) || (t.ir == IR_CLAMP)
		|| !(t.ir inside {IR_SAMPLE, IR_EXTEST, IR_USERCODE, IR_IDENT, IR_CFGIO});
	wire logic sel_bs  = (t.ir == IR_SAMPLE) || (t.ir == IR_EXTEST);
	wire logic sel_32  = (t.ir == IR_USERCODE) || (t.ir == IR_IDENT);
	wire logic sel_ioc = (t.ir == IR_CFGIO);

	always_comb begin
		next_t = t;
		// config_busy comes from the system clock, so it passes two tck flops first
		next_t.busy1 = config_busy;
		next_t.busy2 = t.busy1;
		// requests last one tck; the crossing needs tck slower than sys_clk to see them
		next_t.rc_req = 1'b0;
		next_t.ab_req = 1'b0;
		// tap walk follows tms at every tck rise
		case (t.st)
			JID_RESET: begin
				if (!tms)
					next_t.st = JID_IDLE;
			end
			JID_IDLE: begin
				if (tms)
					next_t.st = JID_SEL_DR;
			end
			JID_SEL_DR: begin
				if (tms)
					next_t.st = JID_SEL_IR;
				else
					next_t.st = JID_CAP_DR;
			end
			JID_CAP_DR: begin
				if (tms)
					next_t.st = JID_EX1_DR;
				else
					next_t.st = JID_SH_DR;
			end
			JID_SH_DR: begin
				if (tms)
					next_t.st = JID_EX1_DR;
			end
			JID_EX1_DR: begin
				if (tms)
					next_t.st = JID_UPD_DR;
				else
					next_t.st = JID_PAU_DR;
			end
			JID_PAU_DR: begin
				if (tms)
					next_t.st = JID_EX2_DR;
			end
			JID_EX2_DR: begin
				if (tms)
					next_t.st = JID_UPD_DR;
				else
					next_t.st = JID_SH_DR;
			end
			JID_UPD_DR: begin
				if (tms)
					next_t.st = JID_SEL_DR;
				else
					next_t.st = JID_IDLE;
			end
			JID_SEL_IR: begin
				if (tms)
					next_t.st = JID_RESET;
				else
					next_t.st = JID_CAP_IR;
			end
			JID_CAP_IR: begin
				if (tms)
					next_t.st = JID_EX1_IR;
				else
					next_t.st = JID_SH_IR;
			end
			JID_SH_IR: begin
				if (tms)
					next_t.st = JID_EX1_IR;
			end
			JID_EX1_IR: begin
				if (tms)
					next_t.st = JID_UPD_IR;
				else
					next_t.st = JID_PAU_IR;
			end
			JID_PAU_IR: begin
				if (tms)
					next_t.st = JID_EX2_IR;
			end
			JID_EX2_IR: begin
				if (tms)
					next_t.st = JID_UPD_IR;
				else
					next_t.st = JID_SH_IR;
			end
			JID_UPD_IR: begin
				if (tms)
					next_t.st = JID_SEL_DR;
				else
					next_t.st = JID_IDLE;
			end
			default:
				next_t.st = JID_RESET;
		endcase
		case (t.st)
			JID_RESET: begin
				next_t.ir = IR_RESET;
				next_t.hold_low = 1'b0;
				next_t.ioc = '0;
			end
			JID_CAP_IR:
				next_t.ir_sh = {{(IR_W-2){1'b0}}, IR_CAPTURE};
			JID_SH_IR:
				next_t.ir_sh = {tdi, t.ir_sh[IR_W-1:1]};
			JID_UPD_IR: begin
				next_t.ir = t.ir_sh;
				if (t.ir_sh == IR_PULSE)
					next_t.rc_req = 1'b1;
				if (t.ir_sh == IR_CFGIO) begin
					next_t.hold_low = 1'b1;
					// abort only when configuration was seen running as the instruction lands
					next_t.ab_req = t.busy2;
				end
			end
			JID_CAP_DR: begin
				next_t.byp = 1'b0;
				if (t.ir == IR_USERCODE)
					next_t.dr32 = user_code;
				else
					next_t.dr32 = ID_VALUE;
				if (sel_bs)
					next_t.bs_sh = pin_in;
				next_t.ioc_sh = t.ioc;
			end
			JID_SH_DR: begin
				next_t.byp = tdi;
				if (sel_32)
					next_t.dr32 = {tdi, t.dr32[UC_W-1:1]};
				if (sel_bs)
					next_t.bs_sh = {tdi, t.bs_sh[BS_W-1:1]};
				if (sel_ioc)
					next_t.ioc_sh = {tdi, t.ioc_sh[IOC_W-1:1]};
			end
			JID_UPD_DR: begin
				if (sel_bs)
					next_t.bs_upd = t.bs_sh;
				if (sel_ioc) begin
					next_t.ioc = t.ioc_sh;
					next_t.hold_low = 1'b0;
				end
			end
			default: begin
			end
		endcase
		// tdo shows the bit that the next shift edge moves out, so it is ready a half cycle early
		case (next_t.st)
			JID_SH_DR: begin
				next_t.tdo_oe = 1'b1;
				if (sel_32)
					next_t.tdo = next_t.dr32[0];
				else if (sel_bs)
					next_t.tdo = next_t.bs_sh[0];
				else if (sel_ioc)
					next_t.tdo = next_t.ioc_sh[0];
				else
					next_t.tdo = next_t.byp;
			end
			JID_SH_IR: begin
				next_t.tdo_oe = 1'b1;
				next_t.tdo = next_t.ir_sh[0];
			end
			default:
				next_t.tdo_oe = 1'b0;
		endcase
	end

	always_ff @(posedge tck) begin
		t <= next_t;
	end
	// tdo changes on the falling edge so the host samples a settled bit at the rise
	always_ff @(negedge tck) begin
		tdo <= t.tdo;
		tdo_oe <= t.tdo_oe;
	end

	// pin control is static between updates, so shifting never disturbs the pins
	for (genvar g = 0; g < BS_W; g++) begin : g_pin
		always_comb begin
			pin_out[g] = core_out[g];
			pin_oe[g] = core_oe[g];
			pin_keep_on[g] = 1'b0;
			case (t.ir)
				IR_EXTEST, IR_CLAMP: begin
					pin_out[g] = t.bs_upd[g];
					pin_oe[g] = 1'b1;
				end
				IR_HIGHZ:
					pin_oe[g] = 1'b0;
				default: begin
				end
			endcase
			// a keeper only acts on a pin that nothing drives
			if (pin_keep[g] && !pin_oe[g])
				pin_keep_on[g] = 1'b1;
		end
	end

	jid_sync_if rc_if();
	jid_sync_if ab_if();
	assign rc_if.tog = t.rc_req;
	assign ab_if.tog = t.ab_req;
	jid_pulse_sync u_rc (.sys_clk(sys_clk), .rst_n(rst_n), .link(rc_if.dst), .pulse(reconfig_pulse));
	jid_pulse_sync u_ab (.sys_clk(sys_clk), .rst_n(rst_n), .link(ab_if.dst), .pulse(config_abort));

	assign config_status_n = ~t.hold_low;
	assign io_element_cfg = t.ioc;

	sequence s_cfgio_update;
		t.st == JID_UPD_IR && t.ir_sh == IR_CFGIO;
	endsequence
	sequence s_ioc_update;
		t.st == JID_UPD_DR && sel_ioc;
	endsequence
	sequence s_pulse_update;
		t.st == JID_UPD_IR && t.ir_sh == IR_PULSE;
	endsequence
	sequence s_five_tms;
		tms [*5];
	endsequence

	a_ir_update: assert property (@(posedge tck) (t.st == JID_UPD_IR) |=> (t.ir == $past(t.ir_sh)))
		else $error("instruction not applied at update");
	a_status_low: assert property (@(posedge tck) s_cfgio_update |=> !config_status_n)
		else $error("status not held low");
	a_highz_pins: assert property (@(posedge tck) (t.ir == IR_HIGHZ) |-> (pin_oe == '0))
		else $error("pins driven in highz");
	a_clamp_pins: assert property (@(posedge tck) (t.ir == IR_CLAMP) |-> (pin_out == t.bs_upd))
		else $error("clamp value wrong");
	a_extest_pins: assert property (@(posedge tck) (t.ir == IR_EXTEST) |-> (pin_out == t.bs_upd && pin_oe == '1))
		else $error("extest pattern not driven");
	a_bypass_path: assert property (@(posedge tck) (t.st == JID_SH_DR && sel_byp) |=> (t.byp == $past(tdi)))
		else $error("bypass bit lost");
	a_keep_wins: assert property (@(posedge tck)
		(pin_keep != '0 && t.ir == IR_HIGHZ) |-> (pin_keep_on == pin_keep))
		else $error("keeper not applied");
	a_cap_id: assert property (@(posedge tck) (t.st == JID_CAP_DR && t.ir == IR_IDENT) |=> (t.dr32 == ID_VALUE))
		else $error("ident not captured");
	a_reconfig_tog: assert property (@(posedge tck) s_pulse_update |=> t.rc_req)
		else $error("reconfig not requested");
	a_status_release: assert property (@(posedge tck) s_ioc_update |=> config_status_n)
		else $error("status not released at io update");
	a_ioc_load: assert property (@(posedge tck) s_ioc_update |=> (t.ioc == $past(t.ioc_sh)))
		else $error("io config not loaded");
	a_status_hold: assert property (@(posedge tck)
		(!config_status_n && t.st != JID_RESET && !(t.st == JID_UPD_DR && sel_ioc)) |=> !config_status_n)
		else $error("status released early");
	a_abort_sent: assert property (@(posedge tck)
		(t.st == JID_UPD_IR && t.ir_sh == IR_CFGIO && t.busy2) |=> t.ab_req)
		else $error("abort not requested");
	a_cap_user: assert property (@(posedge tck)
		(t.st == JID_CAP_DR && t.ir == IR_USERCODE) |=> (t.dr32 == $past(user_code)))
		else $error("user code not captured");
	a_cap_scan: assert property (@(posedge tck) (t.st == JID_CAP_DR && sel_bs) |=> (t.bs_sh == $past(pin_in)))
		else $error("pins not captured");
	a_scan_update: assert property (@(posedge tck) (t.st == JID_UPD_DR && sel_bs) |=> (t.bs_upd == $past(t.bs_sh)))
		else $error("scan pattern not updated");
	a_sample_pins: assert property (@(posedge tck)
		(t.ir == IR_SAMPLE) |-> (pin_out == core_out && pin_oe == core_oe))
		else $error("sample disturbed the pins");
	a_tdo_enable: assert property (@(posedge tck) (t.st == JID_SH_DR || t.st == JID_SH_IR) |-> t.tdo_oe)
		else $error("tdo not enabled in shift");
	a_ir_capture: assert property (@(posedge tck) (t.st == JID_CAP_IR) |=> (t.ir_sh[1:0] == IR_CAPTURE))
		else $error("instruction capture value wrong");
	a_tap_reset: assert property (@(posedge tck) s_five_tms |=> (t.st == JID_RESET))
		else $error("tap not reset by tms");
	a_reconfig_once: assert property (@(posedge sys_clk) disable iff (!rst_n) reconfig_pulse |=> !reconfig_pulse)
		else $error("reconfig pulse too long");
	a_abort_once: assert property (@(posedge sys_clk) disable iff (!rst_n) config_abort |=> !config_abort)
		else $error("abort pulse too long");
	a_rc_crossing: assert property (@(posedge sys_clk) disable iff (!rst_n) reconfig_pulse |-> rc_if.busy)
		else $error("reconfig pulse outside crossing");
endmodule
`default_nettype wire

//--- tb/jid_host.sv
`timescale 1ns/1ps
`default_nettype none
module jid_host (
	// test port
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// tck stands still between frames
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#15 o = tdo;
		tck = 1'b1;
		#15 tck = 1'b0;
	endtask
	task automatic reset();
		logic o;
		for (int i = 0; i < 6; i++) step(i < 5, 1'b0, o);
	endtask
	// idle to shift, n bits lsb first, update, back to idle
	task automatic shift(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic o;
		dout = '0;
		step(1'b1, 1'b0, o);
		if (ir) step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
		step(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
		step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask
endmodule
`default_nettype wire

//--- tb/jtag_instruction_decoder_bench.sv
`timescale 1ns/1ps
`default_nettype none
module jtag_instruction_decoder_bench;
	import jid_pkg::*;
	logic              sys_clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              config_busy = 1'b0;
	logic              tck, tms, tdi, tdo, tdo_oe, reconfig_pulse, config_abort, config_status_n;
	logic [BS_W-1:0]   pin_in = 8'h96, core_out = 8'h4b, core_oe = 8'hf0, pin_keep = 8'h33;
	logic [BS_W-1:0]   pin_out, pin_oe, pin_keep_on;
	logic [UC_W-1:0]   user_code = 32'hcafe_0123;
	logic [IOC_W-1:0]  io_element_cfg;
	logic [31:0]       d;
	int                miscompares = 0, cmp_count = 0, pulses = 0, aborts = 0, cycles = 0;

	jid_decoder u_jid_decoder (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
		.sys_clk(sys_clk), .rst_n(rst_n), .pin_in(pin_in), .core_out(core_out), .core_oe(core_oe),
		.pin_keep(pin_keep), .pin_out(pin_out), .pin_oe(pin_oe), .pin_keep_on(pin_keep_on),
		.user_code(user_code), .config_busy(config_busy), .reconfig_pulse(reconfig_pulse),
		.config_abort(config_abort), .config_status_n(config_status_n), .io_element_cfg(io_element_cfg));
	jid_host u_jid_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

	always #2 sys_clk = ~sys_clk;
	// pulses last one sys_clk, so count them rather than poll
	always @(posedge sys_clk) begin
		if (reconfig_pulse === 1'b1)
			pulses <= pulses + 1;
		if (config_abort === 1'b1)
			aborts <= aborts + 1;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			summarize();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic ir(input logic [IR_W-1:0] code);
		u_jid_host.shift(1'b1, IR_W, {22'h0, code}, d);
		check(d[1:0], IR_CAPTURE);
		repeat (8) @(negedge sys_clk);
	endtask
	task automatic t_ident();
		ir(IR_IDENT);
		u_jid_host.shift(1'b0, ID_W, 32'h0, d);
		check(d, ID_VALUE);
		check(tdo_oe, 1'b0);
		ir(IR_USERCODE);
		u_jid_host.shift(1'b0, UC_W, 32'h0, d);
		check(d, user_code);
	endtask
	task automatic t_bypass();
		logic [IR_W-1:0] codes [4] = '{IR_HIGHZ, IR_CLAMP, IR_BYPASS, 10'h155};
		foreach (codes[i]) begin
			ir(codes[i]);
			u_jid_host.shift(1'b0, 9, 32'h0a5, d);
			check(d[8:0], 9'h14a);
			if (i == 0) check(pin_oe, 8'h00);
			if (i == 0) check(pin_keep_on, pin_keep);
		end
		check(pin_out, core_out);
		check(pin_oe, core_oe);
	endtask
	task automatic t_scan();
		ir(IR_SAMPLE);
		u_jid_host.shift(1'b0, BS_W, 32'h3c, d);
		check(d[7:0], pin_in);
		check(pin_out, core_out);
		ir(IR_CLAMP);
		check(pin_out, 8'h3c);
		ir(IR_EXTEST);
		check(pin_out, 8'h3c);
		@(negedge sys_clk) pin_in = 8'h69;
		u_jid_host.shift(1'b0, BS_W, 32'h81, d);
		check(d[7:0], 8'h69);
		check(pin_out, 8'h81);
	endtask
	task automatic t_cfg();
		int p = pulses;
		int a = aborts;
		ir(IR_PULSE);
		check(pulses, p + 1);
		@(negedge sys_clk) config_busy = 1'b1;
		ir(IR_CFGIO);
		check(aborts, a + 1);
		check(config_status_n, 1'b0);
		u_jid_host.shift(1'b0, IOC_W, 32'h5a, d);
		repeat (8) @(negedge sys_clk);
		check(config_status_n, 1'b1);
		check(io_element_cfg, 8'h5a);
		@(negedge sys_clk) config_busy = 1'b0;
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	initial begin
		u_jid_host.reset();
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk) rst_n = 1'b1;
		repeat (2) @(negedge sys_clk);
		t_ident();
		t_bypass();
		t_scan();
		t_cfg();
		summarize();
	end
endmodule
`default_nettype wire
